//--- rtl/dpbr_consts.svh
`ifndef DPBR_CONSTS_SVH
`define DPBR_CONSTS_SVH
// Functional notes
// - An enabled write edge stores data and extra bits at the location.
// - One width per port serves both its write path and its read path.
// - Location select width follows word width; wider words, fewer slots.
// - Extra bits are stored and returned as plain data, no parity logic.
// - An enabled edge without write strobe loads the addressed word out.
// - A write shows the new word, the old word or holds, per write mode.
// - A closed gate means no read and no write on an edge; outputs hold.
// - An enabled edge with preset active loads the outputs with preset.
// - Port activity follows its own clock edge; outputs change only after.
// - Clock, gate, strobe and preset are active high, each invertible.
// - Total width counts data and extra bits; extra count is a parameter.

// -----------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------
`define DPBR_ADDR_W 4
`define DPBR_CFG_OFS 4'h0
`define DPBR_STAT_OFS 4'h4
`define DPBR_CFG_RST 32'h00000000
`define DPBR_CFG_MASK 32'h00003F3F

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define DPBR_A_MODE_LSB 0
`define DPBR_A_INV_LSB 2
`define DPBR_B_MODE_LSB 8
`define DPBR_B_INV_LSB 10
`define DPBR_MODE_W 2
`define DPBR_INV_W 4
`define DPBR_INV_CLK 0
`define DPBR_INV_GATE 1
`define DPBR_INV_WR 2
`define DPBR_INV_PRE 3
`define DPBR_STAT_A_LSB 0
`define DPBR_STAT_B_LSB 16
`define DPBR_CNT_W 16
`endif

//--- rtl/dpbr_pkg.sv
package dpbr_pkg;
  // Output behaviour while a write is taking place
  typedef enum logic [1:0] {
    WMODE_WRITE_FIRST,
    WMODE_READ_FIRST,
    WMODE_NO_CHANGE
  } dpbr_wmode_t;
endpackage

//--- rtl/dpbr_port.sv
`include "dpbr_consts.svh"
module dpbr_port #(
  parameter int DW = 32,
  parameter int PW = 4,
  parameter int AW = 9,
  parameter logic [DW+PW-1:0] OUTPUT_PRESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_clk,
  input wire logic pin_gate,
  input wire logic pin_strobe,
  input wire logic pin_preset,
  input wire logic [AW-1:0] pin_addr,
  input wire logic [DW-1:0] pin_word,
  input wire logic [PW-1:0] pin_extra,
  input wire logic [`DPBR_INV_W-1:0] inv,
  input dpbr_pkg::dpbr_wmode_t wmode,
  input wire logic [DW+PW-1:0] rd_word,
  output logic op_hit,
  output logic op_wr,
  output logic [AW-1:0] op_addr,
  output logic [DW+PW-1:0] op_word,
  output logic [DW-1:0] read_word,
  output logic [PW-1:0] extra_read
);
  import dpbr_pkg::*;

  localparam int TW = DW + PW;
  localparam int BW = 4 + AW + TW;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [BW-1:0] s1;
    logic [BW-1:0] s2;
    logic clk_prev;
    logic [TW-1:0] latch;
  } dpbr_port_state_t;

  dpbr_port_state_t st_r;
  dpbr_port_state_t st_nxt;
  logic [BW-1:0] pins;
  logic clk_act;
  logic gate_act;
  logic wr_act;
  logic pre_act;
  logic edge_hit;

  // Whole bundle crosses together; fabric holds it steady round the edge
  assign pins = {pin_clk, pin_gate, pin_strobe, pin_preset, pin_addr,
                 pin_extra, pin_word}; // Extra bits ride above data

  // Polarity applied after the synchroniser
  assign clk_act = st_r.s2[BW-1] ^ inv[`DPBR_INV_CLK];
  assign gate_act = st_r.s2[BW-2] ^ inv[`DPBR_INV_GATE];
  assign wr_act = st_r.s2[BW-3] ^ inv[`DPBR_INV_WR];
  assign pre_act = st_r.s2[BW-4] ^ inv[`DPBR_INV_PRE];
  // Flipping the clock inversion can fake one edge; change it idle
  assign edge_hit = clk_act & ~st_r.clk_prev;

  // Requests towards the shared array
  assign op_hit = edge_hit & gate_act;
  assign op_wr = op_hit & wr_act;
  assign op_addr = st_r.s2[TW +: AW];
  assign op_word = st_r.s2[TW-1:0];

  // Same latch feeds both buses, so widths always match
  assign read_word = st_r.latch[DW-1:0];
  assign extra_read = st_r.latch[TW-1:DW]; // No parity logic

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.clk_prev = clk_act;
    if (op_hit) begin
      if (pre_act) begin
        st_nxt.latch = OUTPUT_PRESET_VALUE;
      end else if (!wr_act) begin
        st_nxt.latch = rd_word;
      end else begin
        // Illegal mode code falls back to new data
        unique case (wmode)
          WMODE_READ_FIRST: st_nxt.latch = rd_word;
          WMODE_NO_CHANGE: st_nxt.latch = st_r.latch;
          default: st_nxt.latch = op_word;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  AST_READ_UPDATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_hit && !wr_act && !pre_act |=> st_r.latch == $past(rd_word))
    else $error("read did not load the addressed word");
  AST_WRITE_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_wr && !pre_act && wmode == WMODE_WRITE_FIRST
    |=> {extra_read, read_word} == $past(op_word))
    else $error("new data mode did not show written word");
  AST_READ_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_wr && !pre_act && wmode == WMODE_READ_FIRST
    |=> st_r.latch == $past(rd_word))
    else $error("old data mode did not show prior word");
  AST_NO_CHANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_wr && !pre_act && wmode == WMODE_NO_CHANGE
    |=> $stable({extra_read, read_word}))
    else $error("hold mode changed the outputs");
  AST_PRESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_hit && pre_act |=> st_r.latch == OUTPUT_PRESET_VALUE)
    else $error("preset value not loaded");
  AST_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    edge_hit && !gate_act |-> !op_wr ##1 $stable(st_r.latch))
    else $error("disabled port acted on an edge");
  AST_NO_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !edge_hit |-> !op_hit ##1 $stable(st_r.latch))
    else $error("outputs moved without a port clock edge");
  AST_EDGE_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    edge_hit |=> !edge_hit)
    else $error("one port clock edge acted twice");

  COV_PRESET_ON_READ: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_hit && pre_act && !wr_act);
  COV_HOLD_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_wr && wmode == WMODE_NO_CHANGE);
endmodule

//--- rtl/dpbr_top.sv
`include "dpbr_consts.svh"
module dpbr_top #(
  parameter int A_DATA_W = 32,
  parameter int A_PAR_W = 4,
  parameter int B_DATA_W = 16,
  parameter int B_PAR_W = 2,
  parameter int UNIT_W = 9,
  parameter int DEPTH_UNITS = 2048,
  parameter logic [A_DATA_W+A_PAR_W-1:0] A_PRESET = '0,
  parameter logic [B_DATA_W+B_PAR_W-1:0] B_PRESET = '0,
  localparam int A_TW = A_DATA_W + A_PAR_W,
  localparam int B_TW = B_DATA_W + B_PAR_W,
  localparam int A_RAT = A_TW / UNIT_W,
  localparam int B_RAT = B_TW / UNIT_W,
  localparam int A_AW = $clog2(DEPTH_UNITS / A_RAT),
  localparam int B_AW = $clog2(DEPTH_UNITS / B_RAT)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`DPBR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic port_a_clk,
  input wire logic port_a_access_gate,
  input wire logic port_a_write_strobe,
  input wire logic port_a_output_preset,
  input wire logic [A_AW-1:0] port_a_location_select,
  input wire logic [A_DATA_W-1:0] port_a_write_word,
  input wire logic [A_PAR_W-1:0] port_a_extra_write_bits,
  output logic [A_DATA_W-1:0] port_a_read_word,
  output logic [A_PAR_W-1:0] port_a_extra_read_bits,
  input wire logic port_b_clk,
  input wire logic port_b_access_gate,
  input wire logic port_b_write_strobe,
  input wire logic port_b_output_preset,
  input wire logic [B_AW-1:0] port_b_location_select,
  input wire logic [B_DATA_W-1:0] port_b_write_word,
  input wire logic [B_PAR_W-1:0] port_b_extra_write_bits,
  output logic [B_DATA_W-1:0] port_b_read_word,
  output logic [B_PAR_W-1:0] port_b_extra_read_bits
);
  import dpbr_pkg::*;

  // Each location select points at RAT consecutive units
  localparam int IDX_W = $clog2(DEPTH_UNITS);
  localparam logic [IDX_W-1:0] A_RAT_I = IDX_W'(A_RAT);
  localparam logic [IDX_W-1:0] B_RAT_I = IDX_W'(B_RAT);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic ack;
    logic [`DPBR_CNT_W-1:0] cnt_a;
    logic [`DPBR_CNT_W-1:0] cnt_b;
  } dpbr_top_state_t;

  dpbr_top_state_t st_r;
  dpbr_top_state_t st_nxt;

  // Shared storage, narrowest unit per entry
  logic [UNIT_W-1:0] mem [DEPTH_UNITS];

  logic a_hit;
  logic a_wr;
  logic [A_AW-1:0] a_addr;
  logic [A_TW-1:0] a_word;
  logic [A_TW-1:0] a_rd;
  logic b_hit;
  logic b_wr;
  logic [B_AW-1:0] b_addr;
  logic [B_TW-1:0] b_word;
  logic [B_TW-1:0] b_rd;
  logic [IDX_W-1:0] a_base;
  logic [IDX_W-1:0] b_base;
  logic req;
  logic [31:0] stat;

  assign a_base = IDX_W'(a_addr) * A_RAT_I;
  assign b_base = IDX_W'(b_addr) * B_RAT_I;
  assign req = avs_read | avs_write;
  assign stat = {st_r.cnt_b, st_r.cnt_a};

  // -----------------------------------------------------------------
  // Port front ends
  // -----------------------------------------------------------------
  dpbr_port #(
    .DW(A_DATA_W),
    .PW(A_PAR_W),
    .AW(A_AW),
    .OUTPUT_PRESET_VALUE(A_PRESET)
  ) u_port_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_clk(port_a_clk),
    .pin_gate(port_a_access_gate),
    .pin_strobe(port_a_write_strobe),
    .pin_preset(port_a_output_preset),
    .pin_addr(port_a_location_select),
    .pin_word(port_a_write_word),
    .pin_extra(port_a_extra_write_bits),
    .inv(st_r.cfg[`DPBR_A_INV_LSB +: `DPBR_INV_W]),
    .wmode(dpbr_wmode_t'(st_r.cfg[`DPBR_A_MODE_LSB +: `DPBR_MODE_W])),
    .rd_word(a_rd),
    .op_hit(a_hit),
    .op_wr(a_wr),
    .op_addr(a_addr),
    .op_word(a_word),
    .read_word(port_a_read_word),
    .extra_read(port_a_extra_read_bits)
  );

  dpbr_port #(
    .DW(B_DATA_W),
    .PW(B_PAR_W),
    .AW(B_AW),
    .OUTPUT_PRESET_VALUE(B_PRESET)
  ) u_port_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_clk(port_b_clk),
    .pin_gate(port_b_access_gate),
    .pin_strobe(port_b_write_strobe),
    .pin_preset(port_b_output_preset),
    .pin_addr(port_b_location_select),
    .pin_word(port_b_write_word),
    .pin_extra(port_b_extra_write_bits),
    .inv(st_r.cfg[`DPBR_B_INV_LSB +: `DPBR_INV_W]),
    .wmode(dpbr_wmode_t'(st_r.cfg[`DPBR_B_MODE_LSB +: `DPBR_MODE_W])),
    .rd_word(b_rd),
    .op_hit(b_hit),
    .op_wr(b_wr),
    .op_addr(b_addr),
    .op_word(b_word),
    .read_word(port_b_read_word),
    .extra_read(port_b_extra_read_bits)
  );

  // -----------------------------------------------------------------
  // Array read paths
  // -----------------------------------------------------------------
  // Reads see the array before this edge's write, which gives old data
  genvar g;
  generate
    for (g = 0; g < A_RAT; g++) begin : g_rd_a
      assign a_rd[g*UNIT_W +: UNIT_W] = mem[a_base + IDX_W'(g)];
    end
    for (g = 0; g < B_RAT; g++) begin : g_rd_b
      assign b_rd[g*UNIT_W +: UNIT_W] = mem[b_base + IDX_W'(g)];
    end
  endgenerate

  // -----------------------------------------------------------------
  // Array write path
  // -----------------------------------------------------------------
  // Port A is applied last, so it wins a clash on the same unit
  always_ff @(posedge clk_sys) begin
    if (b_wr) begin
      for (int j = 0; j < B_RAT; j++) begin
        mem[b_base + IDX_W'(j)] <= b_word[j*UNIT_W +: UNIT_W];
      end
    end
    if (a_wr) begin
      for (int j = 0; j < A_RAT; j++) begin
        mem[a_base + IDX_W'(j)] <= a_word[j*UNIT_W +: UNIT_W];
      end
    end
  end

  // -----------------------------------------------------------------
  // Avalon slave and activity counters
  // -----------------------------------------------------------------
  // One wait state: data is ready at the second edge of a request
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata = st_r.rdata;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    if (req && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h00000000;
      if (avs_read && avs_address == `DPBR_CFG_OFS) begin
        st_nxt.rdata = st_r.cfg;
      end else if (avs_read && avs_address == `DPBR_STAT_OFS) begin
        st_nxt.rdata = stat;
      end
    end else if (avs_write && st_r.ack) begin
      // Status and unmapped words ignore writes
      if (avs_address == `DPBR_CFG_OFS) begin
        for (int i = 0; i < 4; i++) begin
          if (avs_byteenable[i]) begin
            st_nxt.cfg[i*8 +: 8] = avs_writedata[i*8 +: 8];
          end
        end
        st_nxt.cfg = st_nxt.cfg & `DPBR_CFG_MASK;
      end
    end
    // Counters wrap; they only show that a port is alive
    if (a_hit) begin
      st_nxt.cnt_a = st_r.cnt_a + `DPBR_CNT_W'(1);
    end
    if (b_hit) begin
      st_nxt.cnt_b = st_r.cnt_b + `DPBR_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.cfg <= `DPBR_CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  AST_A_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    a_wr ##1 a_addr == $past(a_addr) |-> a_rd == $past(a_word))
    else $error("port A write not stored");
  AST_B_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    b_wr && !a_wr ##1 b_addr == $past(b_addr)
    |-> b_rd == $past(b_word))
    else $error("port B write not stored");
  AST_BUS_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not given after one wait state");
  AST_CFG_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_read && !avs_waitrequest && avs_address == `DPBR_CFG_OFS
    |-> avs_readdata == st_r.cfg)
    else $error("configuration read back wrong");

  COV_BOTH_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    a_wr && b_wr);
  COV_CFG_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_address == `DPBR_CFG_OFS);
  COV_A_THEN_B: cover property (@(posedge clk_sys) disable iff (!rst_n)
    a_wr ##[1:20] b_hit);
endmodule

//--- bench/dpbr_fabric.sv
// -----------------------------------------------------------------
// Fabric logic driving one memory port
// -----------------------------------------------------------------
module dpbr_fabric #(
  parameter int AW = 9,
  parameter int DW = 32,
  parameter int PW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] cmd,
  input wire logic [9:0] c_addr,
  input wire logic [35:0] c_val,
  input wire logic [3:0] inv,
  output logic pin_clk,
  output logic [2:0] pins,
  output logic [AW-1:0] pin_addr,
  output logic [DW+PW-1:0] pin_val,
  output logic done
);
  int ph_r;
  // Set pins, raise clock, drop clock, release; 3+ cycles between steps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 0;
      pin_clk <= 1'b0;
      pins <= 3'h0;
      pin_addr <= '0;
      pin_val <= '0;
      done <= 1'b0;
    end else if (ph_r == 0) begin
      done <= 1'b0;
      pin_clk <= inv[0]; // Clock parked at inactive level
      pins <= {~pins[2:1], inv[1]}; // Gate parked inactive
      // Released lines keep changing so no stale value passes
      pin_addr <= ~pin_addr;
      pin_val <= ~pin_val;
      if (go) begin
        ph_r <= 1;
        pins <= cmd ^ inv[3:1]; // Polarity applied per pin
        pin_addr <= c_addr[AW-1:0];
        pin_val <= c_val[DW+PW-1:0];
      end
    end else begin
      ph_r <= (ph_r == 12) ? 0 : ph_r + 1;
      if (ph_r == 4) pin_clk <= ~inv[0]; // Active edge
      if (ph_r == 8) pin_clk <= inv[0];
      done <= (ph_r == 12);
    end
  end
endmodule

//--- bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [35:0] A_PRE = 36'h9A5C33C5A;
  localparam logic [17:0] B_PRE = 18'h2F00F;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] go = 2'h0;
  logic [2:0] cmd = 3'h0;
  logic [9:0] c_addr = 10'h0;
  logic [35:0] c_val = 36'h0;
  logic [3:0] inv_a = 4'h0;
  logic [3:0] inv_b = 4'h0;
  logic [1:0] pclk, done;
  logic [2:0] pa, pb;
  logic [8:0] a_addr;
  logic [9:0] b_addr;
  logic [35:0] a_val, a_out, oa, ob;
  logic [17:0] b_val, b_out;
  logic [35:0] ma [512];
  logic [35:0] qa [$];
  logic [35:0] qb [$];
  logic [31:0] cfg = 32'h0;
  logic [1:0] mode_a = 2'h0;
  logic [1:0] mode_b = 2'h0;
  logic [15:0] cnt_a = 16'h0;
  logic [15:0] cnt_b = 16'h0;
  int failures = 0;
  int n_checks = 0;

  always #25 clk_sys = ~clk_sys;

  dpbr_top #(.A_PRESET(A_PRE), .B_PRESET(B_PRE)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_a_clk(pclk[0]), .port_a_access_gate(pa[0]),
    .port_a_write_strobe(pa[1]), .port_a_output_preset(pa[2]),
    .port_a_location_select(a_addr), .port_a_write_word(a_val[31:0]),
    .port_a_extra_write_bits(a_val[35:32]),
    .port_a_read_word(a_out[31:0]), .port_a_extra_read_bits(a_out[35:32]),
    .port_b_clk(pclk[1]), .port_b_access_gate(pb[0]),
    .port_b_write_strobe(pb[1]), .port_b_output_preset(pb[2]),
    .port_b_location_select(b_addr), .port_b_write_word(b_val[15:0]),
    .port_b_extra_write_bits(b_val[17:16]),
    .port_b_read_word(b_out[15:0]), .port_b_extra_read_bits(b_out[17:16]));

  dpbr_fabric fab_a (.clk_sys(clk_sys),
    .rst_n(rst_n), .go(go[0]), .cmd(cmd), .c_addr(c_addr), .c_val(c_val),
    .inv(inv_a), .pin_clk(pclk[0]), .pins(pa), .pin_addr(a_addr),
    .pin_val(a_val), .done(done[0]));
  dpbr_fabric #(.AW(10), .DW(16), .PW(2)) fab_b (.clk_sys(clk_sys),
    .rst_n(rst_n), .go(go[1]), .cmd(cmd), .c_addr(c_addr), .c_val(c_val),
    .inv(inv_b), .pin_clk(pclk[1]), .pins(pb), .pin_addr(b_addr),
    .pin_val(b_val), .done(done[1]));

  task automatic chk(input string nm, input logic [35:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Oldest note checked as each port finishes its operation
  always @(posedge clk_sys) begin
    if (done[0] === 1'b1 && qa.size() > 0)
      chk("port_a_out", a_out, qa.pop_front());
    if (done[1] === 1'b1 && qb.size() > 0)
      chk("port_b_out", {18'h0, b_out}, qb.pop_front());
  end

  // Avalon access; request held until waitrequest is seen low
  task automatic bus(input bit wr, input logic [3:0] ad,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      results();
    end
    // One idle edge so no strobe is set twice in a time step
    @(posedge clk_sys);
  endtask

  task automatic wcfg(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q, bm;
    for (int i = 0; i < 4; i++) bm[8*i +: 8] = {8{be[i]}};
    bus(1'b1, 4'h0, d, be, q);
    cfg = ((cfg & ~bm) | (d & bm)) & 32'h00003F3F;
    mode_a = cfg[1:0];
    mode_b = cfg[9:8];
    inv_a <= cfg[5:2];
    inv_b <= cfg[13:10];
  endtask

  // Port operation; c = {preset, strobe, gate}, pm selects ports
  task automatic op(input logic [1:0] pm, input logic [2:0] c,
    input logic [9:0] ad, input logic [35:0] v);
    logic [35:0] e, old;
    logic [1:0] md;
    int n;
    for (int p = 0; p < 2; p++) begin
      if (pm[p]) begin
        md = p ? mode_b : mode_a;
        old = p ? 36'(ma[ad[9:1]][ad[0]*18 +: 18]) : ma[ad[8:0]];
        e = p ? ob : oa;
        if (c[0]) begin
          if (c[2]) e = p ? 36'(B_PRE) : A_PRE;
          else if (!c[1] || md == 2'd1) e = old;
          else if (md != 2'd2) e = p ? 36'(v[17:0]) : v;
          if (c[1] && p == 1)
            ma[ad[9:1]][ad[0]*18 +: 18] = v[17:0];
          if (c[1] && p == 0) ma[ad[8:0]] = v;
          if (p == 1) cnt_b++;
          else cnt_a++;
        end
        if (p == 1) ob = e;
        else oa = e;
        if (p == 1) qb.push_back(e);
        else qa.push_back(e);
      end
    end
    cmd <= c;
    c_addr <= ad;
    c_val <= v;
    go <= pm;
    @(posedge clk_sys);
    go <= 2'b00;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done === 2'b00 && n < 40);
    if (n >= 40) begin
      failures++;
      results();
    end
  endtask

  function automatic logic [35:0] rnd();
    return {4'($urandom), 32'($urandom)};
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    oa = '0;
    ob = '0;
    void'($urandom(32'h5DB0));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0, 4'hF, q);
    chk("cfg", 36'(q), 36'h0);
    bus(1'b0, 4'hC, 32'h0, 4'hF, q);
    chk("unmapped", 36'(q), 36'h0);
    $display("test regs done");
    // Prefill low words and the top word; top word read back on both ports
    for (int i = 0; i < 8; i++) op(2'b01, 3'b011, 10'(i), rnd());
    op(2'b01, 3'b011, 10'h1FF, rnd());
    op(2'b01, 3'b001, 10'h1FF, 36'h0);
    op(2'b10, 3'b001, 10'h3FF, 36'h0);
    op(2'b10, 3'b001, 10'h3FE, 36'h0);
    $display("test fill done");
    // Every write mode with both ports writing at the same time
    for (int m = 0; m < 3; m++) begin
      wcfg(32'(m) | (32'(m) << 8), 4'hF);
      op(2'b11, 3'b011, 10'h7, rnd());
      op(2'b11, 3'b001, 10'h6, 36'h0);
    end
    $display("test modes done");
    // Single byte lane, masked bits, mode 3 behaving as write-first
    wcfg(32'hFFFFFFC3, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hF, q);
    chk("cfg", 36'(q), 36'h000000203);
    op(2'b11, 3'b011, 10'h5, rnd());
    // Closed gate: neither written nor read
    op(2'b11, 3'b010, 10'h2, rnd());
    op(2'b11, 3'b001, 10'h2, 36'h0);
    // Preset beats a read; preset with a write still stores
    op(2'b11, 3'b101, 10'h3, 36'h0);
    op(2'b01, 3'b111, 10'h4, rnd());
    op(2'b01, 3'b001, 10'h4, 36'h0);
    $display("test preset done");
    // Gate, strobe and preset inverted on both ports
    wcfg(32'h00003838, 4'hF);
    op(2'b11, 3'b011, 10'h1, rnd());
    op(2'b11, 3'b101, 10'h1, 36'h0);
    op(2'b11, 3'b001, 10'h0, 36'h0);
    // Port clocks inverted too: falling pin edge becomes the active one
    wcfg(32'h00003C3C, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF, q);
    chk("cfg", 36'(q), 36'h000003C3C);
    op(2'b11, 3'b011, 10'h9, rnd());
    op(2'b11, 3'b001, 10'h9, 36'h0);
    bus(1'b0, 4'h4, 32'h0, 4'hF, q);
    chk("status", 36'(q), 36'({cnt_b, cnt_a}));
    $display("test polarity done");
    results();
  end
endmodule
